// file: verilog/ivc_pkg.sv
// Purpose: shared constants and types of the vectored interrupt control block
// Assumes: 4-bit data memory port, 12-bit data memory addresses
// Notes: flag nibbles hold two sources each: {en_hi, req_hi, en_lo, req_lo}
package ivc_pkg;

  localparam int NUM_SRC = 10;
  localparam int NUM_VEC = 7;

  // source indices; vector n (2..7) belongs to source n, vector 1 to sources 0 and 1
  localparam int SRC_INTERVAL_TIMER = 0;
  localparam int SRC_EXT_FOUR = 1;
  localparam int SRC_EXT_ZERO = 2;
  localparam int SRC_EXT_ONE = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_EVENT_COUNTER = 5;
  localparam int SRC_PULSE_GEN = 6;
  localparam int SRC_KEYSCAN = 7;
  localparam int SRC_EXT_TWO = 8;
  localparam int SRC_CLOCK_TIMER = 9;

  // data memory map
  localparam logic [11:0] ADDR_PRIORITY_SEL = 12'hFB2;
  localparam logic [11:0] ADDR_EDGE_SEL_ZERO = 12'hFB4;
  localparam logic [11:0] ADDR_EDGE_SEL_ONE = 12'hFB5;
  localparam logic [11:0] ADDR_FLAGS_BASE = 12'hFB8;
  localparam int NUM_FLAG_NIBBLES = 5;

  // field positions
  localparam int EDGE_FALL_BIT = 0;
  localparam int EDGE_BOTH_BIT = 1;
  localparam int SAMPLE_CLK_BIT = 3;
  localparam int MASTER_EN_BIT = 3;
  localparam int PSW_NEST_HI_BIT = 3;
  localparam int PSW_NEST_LO_BIT = 2;
  localparam logic [3:0] EDGE_SEL_ZERO_MASK = 4'hB;
  localparam logic [3:0] EDGE_SEL_ONE_MASK = 4'h1;

  // reset values
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [NUM_SRC-1:0] FLAGS_RESET = 10'h000;

  // vector table: vector n sits at VECTOR_STEP * n
  localparam logic [13:0] VECTOR_STEP = 14'h0002;

  typedef enum logic [1:0] {
    NEST_S0 = 2'b00,
    NEST_S1 = 2'b01,
    NEST_S2 = 2'b10,
    NEST_BAD = 2'b11
  } ivc_nest_t;

  typedef struct packed {
    logic [11:0] addr;
    logic wr;
    logic bit_op;
    logic [1:0] bit_idx;
    logic [3:0] wdata;
  } ivc_mem_req_t;

  typedef struct packed {
    logic interval_timer_event;
    logic serial_done;
    logic event_counter_match;
    logic pulse_gen_match;
    logic keyscan_event;
    logic clock_timer_event;
  } ivc_periph_evt_t;

  function automatic logic [13:0] vector_addr(input logic [2:0] vec);
    vector_addr = VECTOR_STEP * {11'h000, vec};
  endfunction

  // nibble write, or a single-bit write that leaves the other bits alone
  function automatic logic [3:0] merge_write(input logic [3:0] old, input ivc_mem_req_t req);
    logic [3:0] res;
    res = old;
    if (req.bit_op) begin
      res[req.bit_idx] = req.wdata[0];
    end else begin
      res = req.wdata;
    end
    merge_write = res;
  endfunction

endpackage

// file: verilog/ivc_edge_det.sv
// Purpose: edge detector with optional sampling noise filter for one pin
// Assumes: pin is synchronous to i_sys_clk; i_sample is a one-cycle tick
// Notes: unfiltered pins follow the pin every cycle
`timescale 1ns/1ps
`default_nettype none
module ivc_edge_det (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_pin,
  input wire logic i_filter_en,
  input wire logic i_sample,
  input wire logic i_fall,
  input wire logic i_both,
  output logic o_edge,
  output logic o_level
);
  import ivc_pkg::*;

  logic samp;
  logic next_samp;
  logic next_level;
  logic next_edge;

  always_comb begin
    next_samp = samp;
    next_level = o_level;
    if (!i_filter_en) begin
      next_level = i_pin;
    end else if (i_sample) begin
      next_samp = i_pin;
      // two equal samples in a row pass; a single odd sample is noise
      if (i_pin == samp) begin
        next_level = i_pin;
      end
    end
    if (i_both) begin
      next_edge = next_level ^ o_level;
    end else if (i_fall) begin
      next_edge = o_level & ~next_level;
    end else begin
      next_edge = next_level & ~o_level;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      samp <= 1'b0;
      o_level <= 1'b0;
      o_edge <= 1'b0;
    end else begin
      samp <= next_samp;
      o_level <= next_level;
      o_edge <= next_edge;
    end
  end
endmodule
`default_nettype wire

// file: verilog/ivc_arbiter.sv
// Purpose: picks the vector to accept from the pending vector requests
// Assumes: purely combinational; caller registers the result
// Notes: lower vector number wins
`timescale 1ns/1ps
`default_nettype none
module ivc_arbiter (
  input wire logic [6:0] i_vrq,
  input wire logic i_master_en,
  input wire logic [2:0] i_high_sel,
  input wire ivc_pkg::ivc_nest_t i_nest,
  output logic o_valid,
  output logic [2:0] o_vec
);
  import ivc_pkg::*;

  logic [6:0] elig;

  always_comb begin
    o_valid = 1'b0;
    o_vec = 3'h0;
    for (int k = 0; k < NUM_VEC; k++) begin
      elig[k] = i_vrq[k] & i_master_en
        & ((i_nest == NEST_S0) | ((i_nest == NEST_S1) & (i_high_sel == 3'(k + 1))));
    end
    for (int k = NUM_VEC - 1; k >= 0; k--) begin
      if (elig[k]) begin
        o_valid = 1'b1;
        o_vec = 3'(k + 1);
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/ivc_vectored_irq_ctrl.sv
// Purpose: vectored interrupt control with ten flag pairs and nesting status
// Assumes: all inputs synchronous to i_sys_clk; events are one-cycle pulses
// Notes: hardware sets win over software or acceptance clears in the same cycle
`timescale 1ns/1ps
`default_nettype none
module ivc_vectored_irq_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire ivc_pkg::ivc_mem_req_t i_mem,
  output logic [3:0] o_mem_rdata,
  input wire ivc_pkg::ivc_periph_evt_t i_periph,
  input wire logic i_ext_irq_pin_zero,
  input wire logic i_ext_irq_pin_one,
  input wire logic i_ext_test_pin_two,
  input wire logic i_ext_irq_pin_four,
  input wire logic i_fx_div64_tick,
  input wire logic i_standby,
  input wire logic i_instr_boundary,
  input wire logic i_ei,
  input wire logic i_di,
  input wire logic i_nest_load,
  input wire logic [3:0] i_psw_value,
  output logic o_accept,
  output logic [13:0] o_vector_addr,
  output logic [3:0] o_psw_nest,
  output logic [6:0] o_vector_request_line,
  output logic o_standby_release,
  output logic o_port_ext_zero
);
  import ivc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0] en;
  logic [3:0] edge_select_ext_zero;
  logic [3:0] edge_select_ext_one;
  logic [3:0] priority_select_reg;
  ivc_nest_t nest;

  logic [NUM_SRC-1:0] next_req;
  logic [NUM_SRC-1:0] next_en;
  logic [3:0] next_edge_zero;
  logic [3:0] next_edge_one;
  logic [3:0] next_prio;
  ivc_nest_t next_nest;
  logic next_accept;
  logic [13:0] next_vector_addr;
  logic [3:0] next_rdata;
  logic [6:0] vrq;
  logic next_release;

  logic master_irq_enable;
  logic sample_clock_select;
  logic edge_polarity_ext_one;
  logic [NUM_SRC-1:0] set_evt;
  logic [NUM_SRC-1:0] acc_clear;
  logic edge_zero;
  logic edge_one;
  logic edge_two;
  logic edge_four;
  logic zero_sample;
  logic grant_valid;
  logic [2:0] grant_vec;

  assign master_irq_enable = priority_select_reg[MASTER_EN_BIT];
  assign sample_clock_select = edge_select_ext_zero[SAMPLE_CLK_BIT];
  assign edge_polarity_ext_one = edge_select_ext_one[EDGE_FALL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // external pins
  // sampling halts in standby since the sampling clock is stopped there
  assign zero_sample = ~i_standby & (sample_clock_select ? i_fx_div64_tick : 1'b1);

  ivc_edge_det u_edge_zero (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_ext_irq_pin_zero),
    .i_filter_en(1'b1),
    .i_sample(zero_sample),
    .i_fall(edge_select_ext_zero[EDGE_FALL_BIT]),
    .i_both(edge_select_ext_zero[EDGE_BOTH_BIT]),
    .o_edge(edge_zero),
    .o_level(o_port_ext_zero)
  );

  ivc_edge_det u_edge_one (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_ext_irq_pin_one),
    .i_filter_en(1'b0),
    .i_sample(1'b1),
    .i_fall(edge_polarity_ext_one),
    .i_both(1'b0),
    .o_edge(edge_one),
    .o_level()
  );

  ivc_edge_det u_edge_two (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_ext_test_pin_two),
    .i_filter_en(1'b0),
    .i_sample(1'b1),
    .i_fall(1'b0),
    .i_both(1'b0),
    .o_edge(edge_two),
    .o_level()
  );

  ivc_edge_det u_edge_four (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_ext_irq_pin_four),
    .i_filter_en(1'b0),
    .i_sample(1'b1),
    .i_fall(1'b0),
    .i_both(1'b1),
    .o_edge(edge_four),
    .o_level()
  );

  always_comb begin
    set_evt = '0;
    set_evt[SRC_INTERVAL_TIMER] = i_periph.interval_timer_event;
    set_evt[SRC_SERIAL] = i_periph.serial_done;
    set_evt[SRC_EVENT_COUNTER] = i_periph.event_counter_match;
    set_evt[SRC_PULSE_GEN] = i_periph.pulse_gen_match;
    set_evt[SRC_KEYSCAN] = i_periph.keyscan_event;
    set_evt[SRC_CLOCK_TIMER] = i_periph.clock_timer_event;
    set_evt[SRC_EXT_ZERO] = edge_zero;
    set_evt[SRC_EXT_ONE] = edge_one;
    set_evt[SRC_EXT_TWO] = edge_two;
    set_evt[SRC_EXT_FOUR] = edge_four;
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector requests and arbitration
  always_comb begin
    vrq[0] = (req[SRC_INTERVAL_TIMER] & en[SRC_INTERVAL_TIMER])
      | (req[SRC_EXT_FOUR] & en[SRC_EXT_FOUR]);
    for (int v = 1; v < NUM_VEC; v++) begin
      vrq[v] = req[v + 1] & en[v + 1];
    end
    // test sources wake standby only; they have no vector
    next_release = (|vrq) | (req[SRC_EXT_TWO] & en[SRC_EXT_TWO])
      | (req[SRC_CLOCK_TIMER] & en[SRC_CLOCK_TIMER]);
  end

  ivc_arbiter u_arbiter (
    .i_vrq(vrq),
    .i_master_en(master_irq_enable),
    .i_high_sel(priority_select_reg[2:0]),
    .i_nest(nest),
    .o_valid(grant_valid),
    .o_vec(grant_vec)
  );

  always_comb begin
    acc_clear = '0;
    next_accept = 1'b0;
    next_vector_addr = o_vector_addr;
    if (i_instr_boundary && grant_valid) begin
      next_accept = 1'b1;
      next_vector_addr = vector_addr(grant_vec);
      if (grant_vec == 3'h1) begin
        // with both shared sources enabled software must find the cause
        if (!(en[SRC_INTERVAL_TIMER] && en[SRC_EXT_FOUR])) begin
          acc_clear[SRC_INTERVAL_TIMER] = en[SRC_INTERVAL_TIMER];
          acc_clear[SRC_EXT_FOUR] = en[SRC_EXT_FOUR];
        end
      end else begin
        acc_clear[grant_vec] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes and flag updates
  always_comb begin
    logic [3:0] nib;
    nib = 4'h0;
    next_req = req;
    next_en = en;
    next_edge_zero = edge_select_ext_zero;
    next_edge_one = edge_select_ext_one;
    next_prio = priority_select_reg;
    if (i_mem.wr) begin
      for (int k = 0; k < NUM_FLAG_NIBBLES; k++) begin
        if (i_mem.addr == ADDR_FLAGS_BASE + 12'(k)) begin
          nib = merge_write({en[2*k+1], req[2*k+1], en[2*k], req[2*k]}, i_mem);
          next_req[2*k] = nib[0];
          next_en[2*k] = nib[1];
          next_req[2*k+1] = nib[2];
          next_en[2*k+1] = nib[3];
        end
      end
      if (i_mem.addr == ADDR_EDGE_SEL_ZERO) begin
        next_edge_zero = merge_write(edge_select_ext_zero, i_mem) & EDGE_SEL_ZERO_MASK;
      end
      if (i_mem.addr == ADDR_EDGE_SEL_ONE) begin
        next_edge_one = merge_write(edge_select_ext_one, i_mem) & EDGE_SEL_ONE_MASK;
      end
      if (i_mem.addr == ADDR_PRIORITY_SEL) begin
        next_prio = merge_write(priority_select_reg, i_mem);
      end
    end
    if (i_ei) begin
      next_prio[MASTER_EN_BIT] = 1'b1;
    end
    if (i_di) begin
      next_prio[MASTER_EN_BIT] = 1'b0;
    end
    // a hardware set in the clearing cycle is kept
    next_req = (next_req & ~acc_clear) | set_evt;
  end

  always_comb begin
    next_nest = nest;
    if (next_accept) begin
      next_nest = ivc_nest_t'(nest + 2'h1);
    end else if (i_nest_load) begin
      next_nest = ivc_nest_t'({i_psw_value[PSW_NEST_HI_BIT], i_psw_value[PSW_NEST_LO_BIT]});
    end
  end

  always_comb begin
    next_rdata = 4'h0;
    for (int k = 0; k < NUM_FLAG_NIBBLES; k++) begin
      if (i_mem.addr == ADDR_FLAGS_BASE + 12'(k)) begin
        next_rdata = {en[2*k+1], req[2*k+1], en[2*k], req[2*k]};
      end
    end
    if (i_mem.addr == ADDR_EDGE_SEL_ZERO) begin
      next_rdata = edge_select_ext_zero;
    end
    if (i_mem.addr == ADDR_EDGE_SEL_ONE) begin
      next_rdata = edge_select_ext_one;
    end
    if (i_mem.addr == ADDR_PRIORITY_SEL) begin
      next_rdata = priority_select_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      req <= FLAGS_RESET;
      en <= FLAGS_RESET;
      edge_select_ext_zero <= NIBBLE_RESET;
      edge_select_ext_one <= NIBBLE_RESET;
      priority_select_reg <= NIBBLE_RESET;
      nest <= NEST_S0;
      o_accept <= 1'b0;
      o_vector_addr <= 14'h0000;
      o_mem_rdata <= 4'h0;
      o_psw_nest <= 4'h0;
      o_vector_request_line <= 7'h00;
      o_standby_release <= 1'b0;
    end else begin
      req <= next_req;
      en <= next_en;
      edge_select_ext_zero <= next_edge_zero;
      edge_select_ext_one <= next_edge_one;
      priority_select_reg <= next_prio;
      nest <= next_nest;
      o_accept <= next_accept;
      o_vector_addr <= next_vector_addr;
      o_mem_rdata <= next_rdata;
      o_psw_nest <= {next_nest[1], next_nest[0], 2'b00};
      o_vector_request_line <= vrq;
      o_standby_release <= next_release;
    end
  end
endmodule
`default_nettype wire

// file: sim/ivc_vectored_irq_ctrl_checker.sv
// Purpose: port-level assertions for the vectored interrupt control block
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to the design from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module ivc_vectored_irq_ctrl_checker (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_standby,
  input wire logic i_instr_boundary,
  input wire logic o_accept,
  input wire logic [13:0] o_vector_addr,
  input wire logic [3:0] o_psw_nest,
  input wire logic [6:0] o_vector_request_line,
  input wire logic o_standby_release,
  input wire logic o_port_ext_zero
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_idle_accept;
    o_psw_nest[3:2] == 2'h0 ##1 o_accept;
  endsequence
  // filter output freezes from the first standby cycle; the hold window spans four cycles
  sequence s_standby_hold;
    i_standby [*4];
  endsequence
  property p_reset_clear;
    $rose(i_reset_n) |-> !o_accept && o_psw_nest == 4'h0 && o_vector_request_line == 7'h00;
  endproperty
  property p_accept_bnd;
    o_accept |-> $past(i_instr_boundary);
  endproperty
  property p_idle_step;
    s_idle_accept |-> o_psw_nest[3:2] == 2'h1;
  endproperty
  property p_full_block;
    o_accept |-> $past(o_psw_nest[3:2]) != 2'h2;
  endproperty
  property p_nest_shape;
    o_psw_nest[1:0] == 2'h0 && o_psw_nest[3:2] != 2'h3;
  endproperty
  property p_vec_range;
    o_accept |-> o_vector_addr inside {[14'h0002:14'h000E]} && !o_vector_addr[0];
  endproperty
  property p_vec_hold;
    !o_accept |-> $stable(o_vector_addr);
  endproperty
  property p_release;
    |o_vector_request_line |-> o_standby_release;
  endproperty
  property p_freeze;
    s_standby_hold |-> $stable(o_port_ext_zero);
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared");
  a_accept_bnd: assert property (p_accept_bnd) else $error("accept off boundary");
  a_idle_step: assert property (p_idle_step) else $error("nest did not step");
  a_full_block: assert property (p_full_block) else $error("accept in status 2");
  a_nest_shape: assert property (p_nest_shape) else $error("bad nest field");
  a_vec_range: assert property (p_vec_range) else $error("vector out of table");
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
  a_release: assert property (p_release) else $error("no standby release");
  a_freeze: assert property (p_freeze) else $error("filter ran in standby");
endmodule
`default_nettype wire

// file: sim/ivc_cpu_model.sv
// Purpose: CPU sequencer stand-in giving boundaries and interrupt returns
// Assumes: accept pulses come from the block under test
// Notes: two-deep nest stack, enough for status 0 to 2
`timescale 1ns/1ps
`default_nettype none
module ivc_cpu_model (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_run,
  input wire logic i_reti,
  input wire logic i_accept,
  input wire logic [3:0] i_psw_nest,
  output logic o_boundary,
  output logic o_nest_load,
  output logic [3:0] o_psw_value
);
  logic [1:0] cnt;
  logic [1:0] sp;
  logic [3:0] prev;
  logic [3:0] stk [2];
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      cnt <= 2'h0;
      sp <= 2'h0;
      prev <= 4'h0;
      o_boundary <= 1'h0;
      o_nest_load <= 1'h0;
      o_psw_value <= 4'h0;
    end else begin
      cnt <= i_run ? cnt + 2'h1 : 2'h0;
      o_boundary <= i_run && cnt == 2'h3;
      o_nest_load <= i_reti;
      if (!i_accept) begin
        prev <= i_psw_nest;
      end
      // status saved on entry comes back on return
      if (i_accept) begin
        stk[sp[0]] <= prev;
        sp <= sp + 2'h1;
      end else if (i_reti) begin
        o_psw_value <= (sp != 2'h0) ? stk[sp[1]] : 4'h0;
        sp <= (sp != 2'h0) ? sp - 2'h1 : 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/tb_ivc_vectored_irq_ctrl.sv
// Purpose: self-checking bench for the vectored interrupt control block
// Assumes: inputs change 1 ns after the rising edge
// Notes: flag nibble k holds {en,req} of sources 2k+1 and 2k
`timescale 1ns/1ps
`default_nettype none
bind ivc_vectored_irq_ctrl ivc_vectored_irq_ctrl_checker u_chk (.i_sys_clk, .i_reset_n,
  .i_standby, .i_instr_boundary, .o_accept, .o_vector_addr, .o_psw_nest,
  .o_vector_request_line, .o_standby_release, .o_port_ext_zero);
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_ivc_vectored_irq_ctrl;
  import ivc_pkg::*;
  logic i_sys_clk = 1'h0;
  logic i_reset_n = 1'h0;
  ivc_mem_req_t i_mem = '0;
  ivc_periph_evt_t i_periph = '0;
  logic [3:0] pins = 4'h0;
  logic tick = 1'h0;
  logic i_standby = 1'h0;
  logic ei = 1'h0;
  logic di = 1'h0;
  logic run = 1'h0;
  logic reti = 1'h0;
  logic i_instr_boundary;
  logic i_nest_load;
  logic [3:0] i_psw_value;
  logic [3:0] o_mem_rdata;
  logic o_accept;
  logic [13:0] o_vector_addr;
  logic [3:0] o_psw_nest;
  logic [6:0] o_vector_request_line;
  logic o_standby_release;
  logic o_port_ext_zero;
  int failures = 0;
  int comparisons = 0;
  int ev_off [6] = '{0, 2, 2, 3, 3, 4};
  logic [3:0] ev_nib [6] = '{4'h1, 4'h1, 4'h4, 4'h1, 4'h4, 4'h4};
  always #4 i_sys_clk = ~i_sys_clk;
  ivc_vectored_irq_ctrl u_dut (.i_sys_clk, .i_reset_n, .i_mem, .o_mem_rdata, .i_periph,
    .i_ext_irq_pin_zero(pins[0]), .i_ext_irq_pin_one(pins[1]), .i_ext_test_pin_two(pins[2]),
    .i_ext_irq_pin_four(pins[3]), .i_fx_div64_tick(tick), .i_standby, .i_instr_boundary,
    .i_ei(ei), .i_di(di), .i_nest_load, .i_psw_value, .o_accept, .o_vector_addr,
    .o_psw_nest, .o_vector_request_line, .o_standby_release, .o_port_ext_zero);
  ivc_cpu_model u_cpu (.i_sys_clk, .i_reset_n, .i_run(run), .i_reti(reti),
    .i_accept(o_accept), .i_psw_nest(o_psw_nest), .o_boundary(i_instr_boundary),
    .o_nest_load(i_nest_load), .o_psw_value(i_psw_value));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
    cyc(1);
  endtask
  // one idle cycle after each write keeps the strobe from re-rising in one step
  task automatic wr(input int a, input logic [3:0] d, input logic b = 1'h0,
                    input logic [1:0] idx = 2'h0);
    i_mem = '{12'(a), 1'h1, b, idx, d};
    cyc(1);
    i_mem.wr = 1'h0;
    cyc(1);
  endtask
  task automatic rd(input int a, input logic [3:0] e);
    i_mem.addr = 12'(a);
    cyc(1);
    `CHK("rdata", e, o_mem_rdata)
  endtask
  task automatic clr_all();
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_FLAGS_BASE + k, 4'h0);
    end
  endtask
  task automatic take(input logic [13:0] ea, input logic [3:0] en);
    int i;
    run = 1'h1;
    // step off any accept pulse still standing from a previous call
    cyc(1);
    for (i = 0; i < 20 && o_accept !== 1'h1; i++) begin
      cyc(1);
    end
    run = 1'h0;
    if (i == 20) begin
      failures++;
      close_out();
    end
    `CHK("vector", ea, o_vector_addr)
    `CHK("nest", en, o_psw_nest)
    // let the pulse pass so a following return is not masked by the push
    cyc(1);
  endtask
  task automatic quiet();
    logic seen;
    seen = 1'h0;
    run = 1'h1;
    repeat (12) begin
      cyc(1);
      seen |= o_accept;
    end
    run = 1'h0;
    `CHK("accept", 1'h0, seen)
  endtask
  task automatic pin_chk(input int p, input logic v, input int off, input logic [3:0] e);
    pins[p] = v;
    cyc(4);
    rd(ADDR_FLAGS_BASE + off, e);
    wr(ADDR_FLAGS_BASE + off, 4'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int k = 0; k < 5; k++) begin
      rd(ADDR_FLAGS_BASE + k, 4'h0);
    end
    rd(ADDR_PRIORITY_SEL, 4'h0);
    rd(ADDR_EDGE_SEL_ZERO, 4'h0);
    rd(ADDR_EDGE_SEL_ONE, 4'h0);
    wr(ADDR_EDGE_SEL_ONE, 4'hF);
    rd(ADDR_EDGE_SEL_ONE, 4'h1);
    wr(ADDR_EDGE_SEL_ZERO, 4'hF);
    rd(ADDR_EDGE_SEL_ZERO, 4'hB);
    wr(ADDR_EDGE_SEL_ONE, 4'h0);
    wr(ADDR_EDGE_SEL_ZERO, 4'h0);
    wr(12'hFB6, 4'hF);
    rd(12'hFB6, 4'h0);
    clr_all();
    `CHK("release", 1'h0, o_standby_release)
  endtask
  task automatic t_soft();
    wr(12'hFB9, 4'h1, 1'h1, 2'h1);
    wr(12'hFB9, 4'h1, 1'h1, 2'h0);
    cyc(1);
    `CHK("vrl", 7'h02, o_vector_request_line)
    `CHK("release", 1'h1, o_standby_release)
    quiet();
    pulse(ei);
    rd(ADDR_PRIORITY_SEL, 4'h8);
    take(14'h0004, 4'h4);
    rd(12'hFB9, 4'h2);
    pulse(reti);
    `CHK("nest", 4'h0, o_psw_nest)
    pulse(di);
    rd(ADDR_PRIORITY_SEL, 4'h0);
  endtask
  task automatic t_order();
    wr(12'hFB9, 4'hF);
    wr(12'hFBA, 4'hF);
    wr(12'hFBB, 4'hF);
    pulse(ei);
    for (int n = 2; n < 8; n++) begin
      take(14'(2 * n), 4'h4);
      pulse(reti);
    end
    pulse(di);
    clr_all();
  endtask
  task automatic t_shared();
    wr(12'hFB8, 4'hF);
    pulse(ei);
    take(14'h0002, 4'h4);
    rd(12'hFB8, 4'hF);
    pulse(reti);
    wr(12'hFB8, 4'h3);
    take(14'h0002, 4'h4);
    rd(12'hFB8, 4'h2);
    pulse(reti);
    pulse(di);
    clr_all();
  endtask
  task automatic t_nest();
    wr(ADDR_PRIORITY_SEL, 4'h3);
    wr(12'hFB9, 4'hF);
    pulse(ei);
    take(14'h0004, 4'h4);
    take(14'h0006, 4'h8);
    wr(12'hFBA, 4'h3);
    quiet();
    pulse(reti);
    quiet();
    pulse(reti);
    take(14'h0008, 4'h4);
    pulse(reti);
    pulse(di);
    wr(ADDR_PRIORITY_SEL, 4'h0);
    clr_all();
  endtask
  task automatic t_test_src();
    wr(12'hFBC, 4'hF);
    pulse(ei);
    `CHK("vrl", 7'h00, o_vector_request_line)
    `CHK("release", 1'h1, o_standby_release)
    quiet();
    pulse(di);
    clr_all();
  endtask
  task automatic t_events();
    for (int k = 0; k < 6; k++) begin
      i_periph = ivc_periph_evt_t'(6'h20 >> k);
      cyc(1);
      i_periph = '0;
      rd(ADDR_FLAGS_BASE + ev_off[k], ev_nib[k]);
      wr(ADDR_FLAGS_BASE + ev_off[k], 4'h0);
    end
  endtask
  task automatic t_pins();
    pin_chk(3, 1'h1, 0, 4'h4);
    pin_chk(3, 1'h0, 0, 4'h4);
    pin_chk(1, 1'h1, 1, 4'h4);
    pin_chk(1, 1'h0, 1, 4'h0);
    wr(ADDR_EDGE_SEL_ONE, 4'h1);
    pin_chk(1, 1'h1, 1, 4'h0);
    pin_chk(1, 1'h0, 1, 4'h4);
    pin_chk(2, 1'h1, 4, 4'h1);
    pin_chk(2, 1'h0, 4, 4'h0);
    pins[0] = 1'h1;
    cyc(1);
    pin_chk(0, 1'h0, 1, 4'h0);
    `CHK("port", 1'h0, o_port_ext_zero)
    pin_chk(0, 1'h1, 1, 4'h1);
    `CHK("port", 1'h1, o_port_ext_zero)
    pin_chk(0, 1'h0, 1, 4'h0);
    wr(ADDR_EDGE_SEL_ZERO, 4'h1);
    pin_chk(0, 1'h1, 1, 4'h0);
    pin_chk(0, 1'h0, 1, 4'h1);
    wr(ADDR_EDGE_SEL_ZERO, 4'h2);
    pin_chk(0, 1'h1, 1, 4'h1);
    pin_chk(0, 1'h0, 1, 4'h1);
    wr(ADDR_EDGE_SEL_ZERO, 4'h8);
    wr(12'hFB9, 4'h0);
    pin_chk(0, 1'h1, 1, 4'h0);
    repeat (3) pulse(tick);
    cyc(2);
    rd(12'hFB9, 4'h1);
    i_standby = 1'h1;
    pins[0] = 1'h0;
    repeat (3) pulse(tick);
    `CHK("port", 1'h1, o_port_ext_zero)
    i_standby = 1'h0;
    wr(ADDR_EDGE_SEL_ZERO, 4'h0);
    clr_all();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge i_sys_clk);
    #1;
    i_reset_n = 1'h1;
    cyc(1);
    t_reset();
    t_soft();
    t_order();
    t_shared();
    t_nest();
    t_test_src();
    t_events();
    t_pins();
    close_out();
  end
endmodule
`default_nettype wire
